/* File: rtl/nvsr_pkg.sv */
package nvsr_pkg;

   // ----------------------------------------------------------------
   // report framing
   // ----------------------------------------------------------------
   localparam int          REPORT_LEN    = 64;
   localparam int          IDX_W         = 6;
   localparam logic [5:0]  LAST_IDX      = 6'h3F;

   // ----------------------------------------------------------------
   // command and status codes
   // ----------------------------------------------------------------
   localparam logic [7:0]  CMD_NVRAM_GET = 8'h61;
   localparam logic [7:0]  SUB_CHIP_SET  = 8'h20;
   localparam logic [7:0]  SUB_KEY_PARAM = 8'h30;
   localparam logic [7:0]  STATUS_OK     = 8'h00;
   localparam logic [7:0]  FILL_BYTE     = 8'h00;
   localparam logic [7:0]  RESERVED_BYTE = 8'h00;

   // ----------------------------------------------------------------
   // byte positions
   // ----------------------------------------------------------------
   localparam logic [5:0]  B_CMD         = 6'h00;
   localparam logic [5:0]  B_STATUS      = 6'h01;
   localparam logic [5:0]  B_SUB_ECHO    = 6'h02;
   localparam logic [5:0]  B_SUB_REQ     = 6'h01;
   localparam logic [5:0]  B_PIN7_DES    = 6'h0B;
   localparam logic [5:0]  B_PIN8_DES    = 6'h0C;
   localparam logic [5:0]  B_OUT_LO      = 6'h0D;
   localparam logic [5:0]  B_OUT_HI      = 6'h0E;
   localparam logic [5:0]  B_DIR_LO      = 6'h0F;
   localparam logic [5:0]  B_DIR_HI      = 6'h10;
   localparam logic [5:0]  B_OTHER       = 6'h11;
   localparam logic [5:0]  B_ACCESS      = 6'h12;
   localparam logic [5:0]  B_VID_LO      = 6'h0C;
   localparam logic [5:0]  B_VID_HI      = 6'h0D;
   localparam logic [5:0]  B_PID_LO      = 6'h0E;
   localparam logic [5:0]  B_PID_HI      = 6'h0F;
   localparam logic [5:0]  B_POWER       = 6'h1D;
   localparam logic [5:0]  B_CURRENT     = 6'h1E;

   // ----------------------------------------------------------------
   // field encodings
   // ----------------------------------------------------------------
   localparam logic [7:0]  DES_GPIO      = 8'h00;
   localparam logic [7:0]  DES_CS        = 8'h01;
   localparam logic [7:0]  DES_DEDICATED = 8'h02;
   localparam logic [7:0]  ACC_OPEN      = 8'h00;
   localparam logic [7:0]  ACC_PASSWORD  = 8'h40;
   localparam logic [7:0]  ACC_LOCKED    = 8'h80;
   localparam logic [2:0]  CNT_NONE      = 3'h0;
   localparam logic [2:0]  CNT_FALL      = 3'h1;
   localparam logic [2:0]  CNT_RISE      = 3'h2;
   localparam logic [2:0]  CNT_LOW       = 3'h3;
   localparam logic [2:0]  CNT_HIGH      = 3'h4;
   localparam int          OTH_WAKE_BIT  = 4;
   localparam int          OTH_CNT_LSB   = 1;
   localparam int          OTH_REL_BIT   = 0;
   localparam int          PWR_HOST_BIT  = 7;
   localparam int          PWR_SELF_BIT  = 6;
   localparam int          PWR_WAKE_BIT  = 5;
   localparam int          PIN_HI_BIT    = 8;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  general_pin_seven;
      logic [7:0]  general_pin_eight;
      logic [8:0]  default_output;
      logic [8:0]  default_direction;
      logic        remote_wake;
      logic [2:0]  count_mode;
      logic        bus_hold;
      logic [7:0]  access_code;
   } nvsr_chip_t;

   typedef struct packed {
      logic [15:0] vendor_id;
      logic [15:0] product_id;
      logic        host_powered;
      logic        self_powered;
      logic        wake_capable;
      logic [7:0]  current_2ma;
   } nvsr_key_t;

   typedef struct packed {
      logic        valid;
      logic        last;
      logic [7:0]  data;
   } nvsr_byte_t;

endpackage

/* File: rtl/nvsr_byte_mux.sv */
`timescale 1ns/1ns
module nvsr_byte_mux (
   input  wire logic               sel_key,  // key parameters response
   input  wire logic [5:0]         idx,      // byte index
   input  wire nvsr_pkg::nvsr_chip_t chip,   // chip settings
   input  wire nvsr_pkg::nvsr_key_t  key,    // key parameters
   output logic [7:0]              data      // response byte
);

   logic [7:0] other_byte;
   logic [7:0] power_byte;

   always_comb begin
      other_byte = nvsr_pkg::FILL_BYTE;
      other_byte[nvsr_pkg::OTH_WAKE_BIT] = chip.remote_wake;
      other_byte[nvsr_pkg::OTH_CNT_LSB +: 3] = chip.count_mode;
      other_byte[nvsr_pkg::OTH_REL_BIT] = chip.bus_hold;
      power_byte = nvsr_pkg::FILL_BYTE;
      power_byte[nvsr_pkg::PWR_HOST_BIT] = key.host_powered;
      power_byte[nvsr_pkg::PWR_SELF_BIT] = key.self_powered;
      power_byte[nvsr_pkg::PWR_WAKE_BIT] = key.wake_capable;
   end

   always_comb begin
      data = nvsr_pkg::FILL_BYTE;
      unique case (idx)
         nvsr_pkg::B_CMD:      data = nvsr_pkg::CMD_NVRAM_GET;
         nvsr_pkg::B_STATUS:   data = nvsr_pkg::STATUS_OK;
         nvsr_pkg::B_SUB_ECHO: data = sel_key ? nvsr_pkg::SUB_KEY_PARAM
                                              : nvsr_pkg::SUB_CHIP_SET;
         default:              data = nvsr_pkg::FILL_BYTE;
      endcase
      if (sel_key) begin
         if (idx == nvsr_pkg::B_VID_LO) data = key.vendor_id[7:0];
         if (idx == nvsr_pkg::B_VID_HI) data = key.vendor_id[15:8];
         if (idx == nvsr_pkg::B_PID_LO) data = key.product_id[7:0];
         if (idx == nvsr_pkg::B_PID_HI) data = key.product_id[15:8];
         if (idx == nvsr_pkg::B_POWER) data = power_byte;
         if (idx == nvsr_pkg::B_CURRENT) data = key.current_2ma;
      end else begin
         if (idx == nvsr_pkg::B_PIN7_DES) data = chip.general_pin_seven;
         if (idx == nvsr_pkg::B_PIN8_DES) data = chip.general_pin_eight;
         if (idx == nvsr_pkg::B_OUT_LO) data = chip.default_output[7:0];
         if (idx == nvsr_pkg::B_OUT_HI) begin
            data = {7'h00, chip.default_output[nvsr_pkg::PIN_HI_BIT]};
         end
         if (idx == nvsr_pkg::B_DIR_LO) begin
            data = chip.default_direction[7:0];
         end
         if (idx == nvsr_pkg::B_DIR_HI) begin
            data = {7'h00, chip.default_direction[nvsr_pkg::PIN_HI_BIT]};
         end
         if (idx == nvsr_pkg::B_OTHER) data = other_byte;
         if (idx == nvsr_pkg::B_ACCESS) data = chip.access_code;
      end
   end

endmodule

/* File: rtl/nvsr_responder.sv */
// Function
// - bytes 11, 12 give pin seven and eight designation codes 00/01/02
// - bytes 13, 14 give default output word, low byte first
// - bytes 15, 16 give default direction word, low byte first
// - byte 17 bit 4 reports remote wake-up enable
// - byte 17 bits 3..1 give interrupt counting mode code
// - byte 17 bit 0 is the bus hold option
// - byte 18 is the access code 00, 40 or 80
// - key response echoes 61, status 00, sub-command 30
// - byte 29 holds host, self powered and wake capable bits 7..5
// - byte 30 holds requested current in 2 mA units
`timescale 1ns/1ns
module nvsr_responder (
   input  wire logic                 CLK_SYS,     // 20 MHz system clock
   input  wire logic                 SYS_RST,     // async reset, high
   input  wire logic                 CLK_EN,      // freezes state when low
   input  wire logic                 CMD_VALID,   // command byte valid
   input  wire logic [7:0]           CMD_DATA,    // command byte
   input  wire logic                 CMD_LAST,    // last command byte
   output logic                      CMD_READY,   // command byte accepted
   output logic                      RSP_VALID,   // response byte valid
   output logic [7:0]                RSP_DATA,    // response byte
   output logic                      RSP_LAST,    // byte 63 of response
   input  wire logic                 RSP_READY,   // sink takes byte
   output logic                      CMD_IGNORED, // report not answered
   input  wire nvsr_pkg::nvsr_chip_t CHIP_SET,    // stored chip settings
   input  wire nvsr_pkg::nvsr_key_t  KEY_SET      // stored key parameters
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      NVSR_RECV = 3'b001,
      NVSR_SEND = 3'b010,
      NVSR_DROP = 3'b100
   } nvsr_state_t;

   nvsr_state_t state_q;
   nvsr_state_t state_d;
   logic [5:0]  idx_q;
   logic [5:0]  idx_d;
   logic [7:0]  cmd_q;
   logic [7:0]  cmd_d;
   logic [7:0]  sub_q;
   logic [7:0]  sub_d;
   logic        bad_q;
   logic        bad_d;
   logic        sel_key_q;
   logic        sel_key_d;
   logic [7:0]  data_q;
   logic [7:0]  data_d;
   logic        ign_q;
   logic        ign_d;
   logic [7:0]  mux_byte;
   logic        take;
   logic        known;

   assign CMD_READY   = (state_q == NVSR_RECV);
   assign RSP_VALID   = (state_q == NVSR_SEND);
   assign RSP_DATA    = data_q;
   assign RSP_LAST    = RSP_VALID && (idx_q == nvsr_pkg::LAST_IDX);
   assign CMD_IGNORED = ign_q;
   assign take        = CMD_VALID && CMD_READY;

   // ----------------------------------------------------------------
   // response byte source
   // ----------------------------------------------------------------
   nvsr_byte_mux u_mux (
      .sel_key (sel_key_d),
      .idx     (idx_d),
      .chip    (CHIP_SET),
      .key     (KEY_SET),
      .data    (mux_byte)
   );

   // ----------------------------------------------------------------
   // command parse and response sequencing
   // ----------------------------------------------------------------
   always_comb begin
      state_d   = state_q;
      idx_d     = idx_q;
      cmd_d     = cmd_q;
      sub_d     = sub_q;
      bad_d     = bad_q;
      sel_key_d = sel_key_q;
      data_d    = data_q;
      ign_d     = 1'b0;
      known     = 1'b0;
      unique case (state_q)
         NVSR_RECV: begin
            if (take) begin
               if (idx_q == nvsr_pkg::B_CMD) begin
                  cmd_d = CMD_DATA;
                  bad_d = 1'b0;
               end else if (idx_q == nvsr_pkg::B_SUB_REQ) begin
                  sub_d = CMD_DATA;
               end else if (CMD_DATA != nvsr_pkg::RESERVED_BYTE) begin
                  bad_d = 1'b1;
               end
               idx_d = idx_q + 6'h01;
               if (CMD_LAST || idx_q == nvsr_pkg::LAST_IDX) begin
                  known = (cmd_d == nvsr_pkg::CMD_NVRAM_GET) && !bad_d &&
                          (idx_q == nvsr_pkg::LAST_IDX) &&
                          (sub_d == nvsr_pkg::SUB_CHIP_SET ||
                           sub_d == nvsr_pkg::SUB_KEY_PARAM);
                  idx_d = nvsr_pkg::B_CMD;
                  if (known) begin
                     sel_key_d = (sub_d == nvsr_pkg::SUB_KEY_PARAM);
                     state_d   = NVSR_SEND;
                  end else begin
                     ign_d = 1'b1;
                     if (!CMD_LAST) state_d = NVSR_DROP;
                  end
               end
            end
         end
         NVSR_DROP: begin
            if (CMD_VALID && CMD_LAST) state_d = NVSR_RECV;
         end
         NVSR_SEND: begin
            if (RSP_READY) begin
               idx_d = idx_q + 6'h01;
               if (idx_q == nvsr_pkg::LAST_IDX) begin
                  idx_d   = nvsr_pkg::B_CMD;
                  state_d = NVSR_RECV;
               end
            end
         end
         default: begin
            state_d = NVSR_RECV;
            idx_d   = nvsr_pkg::B_CMD;
         end
      endcase
      if (state_d == NVSR_SEND) data_d = mux_byte;
   end

   // drop state takes no bytes and waits until the last byte of the oversize report is offered
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         state_q   <= NVSR_RECV;
         idx_q     <= nvsr_pkg::B_CMD;
         cmd_q     <= nvsr_pkg::FILL_BYTE;
         sub_q     <= nvsr_pkg::FILL_BYTE;
         bad_q     <= 1'b0;
         sel_key_q <= 1'b0;
         data_q    <= nvsr_pkg::FILL_BYTE;
         ign_q     <= 1'b0;
      end else if (CLK_EN) begin
         state_q   <= state_d;
         idx_q     <= idx_d;
         cmd_q     <= cmd_d;
         sub_q     <= sub_d;
         bad_q     <= bad_d;
         sel_key_q <= sel_key_d;
         data_q    <= data_d;
         ign_q     <= ign_d;
      end
   end

endmodule

/* File: bench/nvsr_responder_properties.sv */
`timescale 1ns/1ns
module nvsr_responder_props (
   input  wire logic       CLK_SYS,     // system clock
   input  wire logic       SYS_RST,     // async reset, high
   input  wire logic       CLK_EN,      // clock enable
   input  wire logic       CMD_VALID,   // command byte valid
   input  wire logic       CMD_LAST,    // last command byte
   input  wire logic       CMD_READY,   // command byte accepted
   input  wire logic       RSP_VALID,   // response byte valid
   input  wire logic [7:0] RSP_DATA,    // response byte
   input  wire logic       RSP_LAST,    // final response byte
   input  wire logic       RSP_READY,   // sink takes byte
   input  wire logic       CMD_IGNORED  // report not answered
);
   logic [5:0] idx_q;
   logic [5:0] idx_d;
   logic       tk;
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SYS_RST);
   assign tk = RSP_VALID && RSP_READY && CLK_EN;
   // index of the response byte now on offer
   always_comb begin
      idx_d = !RSP_VALID ? 6'h00 : (tk ? idx_q + 6'h01 : idx_q);
   end
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         idx_q <= 6'h00;
      end else begin
         idx_q <= idx_d;
      end
   end
   AST_ANSWER: assert property (CMD_VALID && CMD_READY
      && CMD_LAST && CLK_EN |=> RSP_VALID != CMD_IGNORED)
      else $error("no single answer");
   AST_BUSY: assert property (RSP_VALID |-> !CMD_READY)
      else $error("command taken during response");
   AST_HOLD: assert property (RSP_VALID && !RSP_READY
      |=> RSP_VALID && $stable(RSP_DATA)) else $error("byte not held");
   AST_ECHO: assert property ($rose(RSP_VALID) |-> RSP_DATA == 8'h61)
      else $error("command not echoed");
   AST_STATUS: assert property (RSP_VALID && idx_q == 6'h01
      |-> RSP_DATA == 8'h00) else $error("bad status");
   AST_SUB: assert property (RSP_VALID && idx_q == 6'h02
      |-> RSP_DATA inside {8'h20, 8'h30}) else $error("bad sub echo");
   AST_LAST: assert property (RSP_VALID
      |-> RSP_LAST == (idx_q == 6'h3F)) else $error("last misplaced");
   AST_END: assert property (tk && RSP_LAST
      |=> !RSP_VALID && CMD_READY) else $error("response overran");
   AST_IGN: assert property (CMD_IGNORED
      |=> !CMD_IGNORED && !RSP_VALID) else $error("ignore not a pulse");
   cover property ($rose(RSP_VALID));
   cover property (CMD_IGNORED);
   cover property (RSP_VALID && !RSP_READY);
endmodule
bind nvsr_responder nvsr_responder_props u_props (.CLK_SYS(CLK_SYS),
   .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .CMD_VALID(CMD_VALID),
   .CMD_LAST(CMD_LAST), .CMD_READY(CMD_READY), .RSP_VALID(RSP_VALID),
   .RSP_DATA(RSP_DATA), .RSP_LAST(RSP_LAST), .RSP_READY(RSP_READY),
   .CMD_IGNORED(CMD_IGNORED));

/* File: bench/nvsr_host_model.sv */
`timescale 1ns/1ns
module nvsr_host_model (
   input  wire logic       clk,       // system clock
   output logic            cmd_valid, // command byte valid
   output logic [7:0]      cmd_data,  // command byte
   output logic            cmd_last,  // last command byte
   input  wire logic       cmd_ready, // byte taken
   input  wire logic       rsp_valid, // response byte valid
   input  wire logic [7:0] rsp_data,  // response byte
   input  wire logic       rsp_last,  // final response byte
   output logic            rsp_ready, // sink ready
   input  wire logic       ignored    // report dropped
);
   logic [7:0] rx [64];
   int         n_rx;
   int         n_ign;
   int         last_at;
   logic       stall;
   initial begin
      cmd_valid = 1'b0;
      cmd_data = 8'h00;
      cmd_last = 1'b0;
      rsp_ready = 1'b1;
      stall = 1'b0;
   end
   // one report; bad names a byte made nonzero, stop the byte marked last
   task automatic send(input logic [7:0] c, s, input int bad, stop);
      for (int i = 0; i <= stop; i++) begin
         cmd_valid <= 1'b1;
         cmd_data <= i == 0 ? c : i == 1 ? s : i == bad ? 8'h5A : 8'h00;
         cmd_last <= (i == stop);
         do @(posedge clk); while (cmd_ready !== 1'b1);
         #1;
      end
      cmd_valid <= 1'b0;
      cmd_last <= 1'b0;
      cmd_data <= ~cmd_data; // released line does not keep its value
   endtask
   always @(posedge clk) begin
      if (rsp_valid === 1'b1 && rsp_ready) begin
         rx[n_rx % 64] <= rsp_data;
         if (rsp_last === 1'b1) last_at <= n_rx;
         n_rx <= n_rx + 1;
      end
      if (ignored === 1'b1) n_ign <= n_ign + 1;
      #1 rsp_ready <= stall ? ~rsp_ready : 1'b1;
   end
endmodule

/* File: bench/nvsr_responder_test.sv */
`timescale 1ns/1ns
module nvsr_responder_test;
   logic                 clk = 1'b0;
   logic                 rst = 1'b1;
   logic                 cv, cl, cr, rv, rl, rr, ign;
   logic [7:0]           cd, rd;
   nvsr_pkg::nvsr_chip_t chip = '0;
   nvsr_pkg::nvsr_key_t  key = '0;
   int                   n_mismatch = 0;
   int                   check_count = 0;
   always #25 clk = ~clk;
   nvsr_responder uut (.CLK_SYS(clk), .SYS_RST(rst), .CLK_EN(1'b1),
      .CMD_VALID(cv), .CMD_DATA(cd), .CMD_LAST(cl), .CMD_READY(cr),
      .RSP_VALID(rv), .RSP_DATA(rd), .RSP_LAST(rl), .RSP_READY(rr),
      .CMD_IGNORED(ign), .CHIP_SET(chip), .KEY_SET(key));
   nvsr_host_model hm (.clk(clk), .cmd_valid(cv), .cmd_data(cd),
      .cmd_last(cl), .cmd_ready(cr), .rsp_valid(rv), .rsp_data(rd),
      .rsp_last(rl), .rsp_ready(rr), .ignored(ign));
   task automatic chk(input logic [7:0] got, exp, input string what);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_n(input int got, exp, input string what);
      check_count++;
      if (got != exp) begin
         n_mismatch++;
         $display("ERROR t=%0t %s got %0d exp %0d", $time, what, got, exp);
      end
   endtask
   task automatic run(input logic [7:0] c, s, input int bad = 99, stop = 63);
      int w;
      hm.n_rx = 0;
      hm.n_ign = 0;
      hm.last_at = -1;
      hm.send(c, s, bad, stop);
      w = 0;
      while (hm.n_rx < 64 && hm.n_ign == 0 && w < 300) begin
         @(posedge clk);
         #1;
         w++;
      end
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      #(4000 * 50);
      n_mismatch++;
      $display("ERROR t=%0t watchdog expired", $time);
      tally_and_finish();
   end
   initial begin
      repeat (12) @(posedge clk);
      #1 rst = 1'b0;
      for (int k = 0; k < 5; k++) begin
         chip.general_pin_seven = 8'(k % 3);
         chip.general_pin_eight = 8'((k + 1) % 3);
         chip.default_output = 9'h1A5 ^ 9'(k * 37);
         chip.default_direction = 9'h05A ^ 9'(k * 77);
         chip.remote_wake = k[0];
         chip.count_mode = 3'(k);
         chip.bus_hold = ~k[0];
         chip.access_code = 8'(k % 3) << 6;
         hm.stall = k[0];
         run(8'h61, 8'h20);
         chk_n(hm.n_rx, 64, "length");
         chk_n(hm.last_at, 63, "last");
         chk(hm.rx[0], 8'h61, "cmd");
         chk(hm.rx[1], 8'h00, "status");
         chk(hm.rx[2], 8'h20, "sub");
         chk(hm.rx[11], 8'(k % 3), "pin7");
         chk(hm.rx[12], 8'((k + 1) % 3), "pin8");
         chk(hm.rx[13], chip.default_output[7:0], "out lo");
         chk(hm.rx[14], {7'h00, chip.default_output[8]}, "out hi");
         chk(hm.rx[15], chip.default_direction[7:0], "dir lo");
         chk(hm.rx[16], {7'h00, chip.default_direction[8]}, "dir hi");
         chk(hm.rx[17], {3'h0, k[0], 3'(k), ~k[0]}, "other");
         chk(hm.rx[18], 8'(k % 3) << 6, "access");
         $display("chip settings test %0d done", k);
      end
      run(8'h62, 8'h20);
      chk_n(hm.n_rx, 0, "bad cmd answered");
      chk_n(hm.n_ign, 1, "bad cmd pulse");
      run(8'h61, 8'h50, 99, 63);
      chk_n(hm.n_rx, 0, "bad sub answered");
      chk_n(hm.n_ign, 1, "bad sub pulse");
      run(8'h61, 8'h30, 40, 63);
      chk_n(hm.n_rx, 0, "nonzero answered");
      chk_n(hm.n_ign, 1, "nonzero pulse");
      run(8'h61, 8'h20, 99, 30);
      chk_n(hm.n_rx, 0, "refused answered");
      chk_n(hm.n_ign, 1, "refused pulse");
      // oversize report drops; the held last byte is then a short report
      run(8'h62, 8'h20, 99, 64);
      chk_n(hm.n_rx, 0, "oversize answered");
      chk_n(hm.n_ign, 2, "oversize pulses");
      $display("refusal tests done");
      for (int j = 0; j < 2; j++) begin
         key.vendor_id = 16'hA1B2 ^ 16'(j * 257);
         key.product_id = 16'hC3D4 + 16'(j);
         {key.host_powered, key.self_powered, key.wake_capable} =
            j[0] ? 3'h5 : 3'h2;
         key.current_2ma = 8'h32 + 8'(j);
         hm.stall = j[0];
         run(8'h61, 8'h30);
         chk_n(hm.n_rx, 64, "length");
         chk(hm.rx[0], 8'h61, "cmd");
         chk(hm.rx[1], 8'h00, "status");
         chk(hm.rx[2], 8'h30, "sub");
         chk(hm.rx[12], key.vendor_id[7:0], "vid lo");
         chk(hm.rx[13], key.vendor_id[15:8], "vid hi");
         chk(hm.rx[14], key.product_id[7:0], "pid lo");
         chk(hm.rx[15], key.product_id[15:8], "pid hi");
         chk(hm.rx[29], j[0] ? 8'hA0 : 8'h40, "power");
         chk(hm.rx[30], 8'h32 + 8'(j), "current");
         $display("key parameters test %0d done", j);
      end
      tally_and_finish();
   end
endmodule
